// ---- far_side_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input  wire logic               clk_sys_i,
  input  wire logic               arst_n_i,
  input  wire lockout_pkg::step_e step_req_i,
  input  wire logic [2:0]         bad_step_i,
  input  wire logic [3:0]         detail_i,
  output lockout_pkg::step_rsp_s  step_rsp_o,
  input  wire logic               tmr_start_i,
  input  wire logic [15:0]        tmr_dly_i,
  output logic                    tmr_irq_o,
  input  wire logic               dma_start_i,
  input  wire logic [15:0]        dma_dly_i,
  output logic                    dma_irq_o,
  input  wire logic               cop_init_i,
  input  wire logic               cop_ok_i,
  output logic                    cop_ready_o,
  input  wire logic               raise_i,
  input  wire logic [7:0]         code_i,
  input  wire logic               cop_ack_i,
  output lockout_pkg::cop_rep_s   cop_rep_o
);
  import lockout_pkg::*;
  step_e       last_q;
  logic [1:0]  age_q;
  logic [15:0] t_q;
  logic [15:0] d_q;
  logic        seen_q;
  ////////////////////////////////////////////////////////////////////////////
  // one answer per step, two cycles after the request shows
  assign step_rsp_o = {(step_req_i != STEP_NONE) && (step_req_i == last_q) && (age_q == 2'h1),
                       step_req_i != bad_step_i, detail_i};
  // a delay of zero never interrupts
  assign tmr_irq_o = (t_q != 16'h0000) && (t_q == tmr_dly_i);
  assign dma_irq_o = (d_q != 16'h0000) && (d_q == dma_dly_i);
  assign cop_ready_o = seen_q & cop_ok_i;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_q    <= STEP_NONE;
      age_q     <= 2'h0;
      t_q       <= 16'h0000;
      d_q       <= 16'h0000;
      seen_q    <= 1'b0;
      cop_rep_o <= 9'h000;
    end else begin
      last_q <= step_req_i;
      age_q  <= (step_req_i != last_q) ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
      t_q    <= tmr_start_i ? 16'h0001 : (tmr_irq_o || t_q == 16'h0000) ? 16'h0000 : t_q + 1'b1;
      d_q    <= dma_start_i ? 16'h0001 : (dma_irq_o || d_q == 16'h0000) ? 16'h0000 : d_q + 1'b1;
      seen_q <= seen_q | cop_init_i;
      // request held until taken; released code lines stop showing the old value
      if (raise_i) begin
        cop_rep_o <= {1'b1, code_i};
      end else if (cop_ack_i) begin
        cop_rep_o <= {1'b0, ~cop_rep_o.code};
      end
    end
  end
endmodule : far_side_model
`default_nettype wire

// ---- lockout_supervisor.sv ----
// How it works
// - failures are reported as an 8-bit code; 01-2F system, above is application.
// - a hardware-caused reset (watchdog, NMI) records code 00.
// - a code-00 reset never locks out alone; it only counts toward the limit.
// - processor register, flag or branch test failure locks out with 01.
// - power-on RAM failure locks with 02; background RAM failure resets and reruns.
// - program memory sums to zero; power-on nonzero sum locks out with 03.
// - background sum failure resets only after two consecutive failures.
// - excessive resets set flag bit 3, lock, code 08 unless a cause is pending.
// - display RAM four-byte write/read check; mismatch locks out with 09.
// - each control register is tested; failure locks with 11 to 1A by register.
// - peripherals off with interrupts enabled; any interrupt locks out with 1B.
// - reference timer set for 1 ms; no interrupt by 2 ms locks with 1C.
// - timer count outside 3% gives 1D, reports fast or slow and count.
// - dma_channel_zero copies 16 bytes; no completion interrupt in time gives 1E.
// - copied bytes compared with source; any difference locks out with 1F.
// - coprocessor codes 31-35 shown and reset; still present after three resets locks.
// - coprocessor not initialised after three attempts locks out with 31.
// - code 35 raises out-of-sync alarm; reset once it persists five seconds.
// - flag bit 3 and lockout flag are set on the 100th reset request since power-on.
// - flag bit 7 marks fatal lockout, held until power is removed.
`timescale 1ns/1ps
`default_nettype none
module lockout_supervisor #(
  parameter int unsigned TMR_NOM_CYC_P  = lockout_pkg::TMR_NOM_CYC,
  parameter int unsigned TMR_MAX_CYC_P  = lockout_pkg::TMR_MAX_CYC,
  parameter int unsigned DMA_TMO_CYC_P  = lockout_pkg::DMA_TMO_CYC,
  parameter int unsigned INIT_TMO_CYC_P = lockout_pkg::INIT_TMO_CYC,
  parameter int unsigned OOS_CYC_P      = lockout_pkg::OOS_CYC,
  parameter int unsigned TCW            = $clog2(TMR_MAX_CYC_P + 1)
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   arst_n_i,
  output lockout_pkg::step_e          step_req_o,
  input  wire lockout_pkg::step_rsp_s step_rsp_i,
  output logic                        periph_off_o,
  input  wire logic                   periph_irq_i,
  output logic                        tmr_start_o,
  input  wire logic                   tmr_irq_i,
  output logic                        dma_start_o,
  input  wire logic                   dma_irq_i,
  output logic                        cop_init_o,
  input  wire logic                   cop_ready_i,
  input  wire lockout_pkg::cop_rep_s  cop_rep_i,
  output logic                        cop_ack_o,
  output logic                        oos_alarm_o,
  input  wire logic                   hw_reset_i,
  input  wire logic                   bg_ram_fail_i,
  input  wire logic                   bg_sum_done_i,
  input  wire logic                   bg_sum_fail_i,
  input  wire logic                   app_err_i,
  input  wire logic [7:0]             app_code_i,
  output logic                        sys_reset_o,
  output logic                        run_o,
  output logic                        lockout_o,
  output lockout_pkg::err_rep_s       err_o,
  output logic                        tmr_fast_o,
  output logic                        tmr_slow_o,
  output logic [TCW-1:0]              tmr_count_o
);
  import lockout_pkg::*;

  localparam int unsigned CNT_W = 28;
  localparam logic [CNT_W-1:0] DMA_LAST  = CNT_W'(DMA_TMO_CYC_P - 1);
  localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_TMO_CYC_P - 1);
  localparam logic [CNT_W-1:0] HOT_LAST  = CNT_W'(HOT_WIN_CYC - 1);
  localparam logic [CNT_W-1:0] OOS_LAST  = CNT_W'(OOS_CYC_P - 1);

  typedef enum logic [12:0] {
    S_CPU  = 13'h0001,
    S_RAM  = 13'h0002,
    S_SUM  = 13'h0004,
    S_DISP = 13'h0008,
    S_CREG = 13'h0010,
    S_HOT  = 13'h0020,
    S_TMR  = 13'h0040,
    S_DMA  = 13'h0080,
    S_DCMP = 13'h0100,
    S_COP  = 13'h0200,
    S_RUN  = 13'h0400,
    S_RST  = 13'h0800,
    S_LOCK = 13'h1000
  } state_e;

  state_e           state_q;
  state_e           state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] oos_q;
  logic [1:0]       tries_q;
  logic [1:0]       sum_fail_q;
  logic [1:0]       cop_rst_q;
  logic [6:0]       rst_cnt_q;
  logic [7:0]       code_q;
  logic [7:0]       flags_q;

  logic             lock_go;
  logic [7:0]       lock_code;
  logic             excess;
  logic             rst_go;
  logic [7:0]       rst_code;
  logic             rst_bg;
  logic             cop_take;
  logic             retry;

  logic             tmr_done;
  logic             tmr_dead;

  ////////////////////////////////////////////////////////////////////////////
  // decoding
  wire first     = (cnt_q == '0);
  wire step_ok   = step_rsp_i.done & step_rsp_i.pass;
  wire step_bad  = step_rsp_i.done & ~step_rsp_i.pass;
  wire st_run    = (state_q == S_RUN);
  wire cop_range = (cop_rep_i.code >= ERR_COP_INIT) && (cop_rep_i.code <= ERR_COP_LAST);
  wire cop_oos   = cop_rep_i.req & (cop_rep_i.code == ERR_COP_OOS);
  wire cop_now   = cop_rep_i.req & cop_range & ~cop_oos;
  wire oos_due   = cop_oos & (oos_q == OOS_LAST);
  wire sum_two   = bg_sum_done_i & bg_sum_fail_i & (sum_fail_q == SUM_FAIL_LIMIT - 2'd1);
  wire [7:0] creg_code = ERR_CREG_BASE + {4'h0, step_rsp_i.detail};

  assign step_req_o   = (state_q == S_CPU)  ? STEP_CPU  :
                        (state_q == S_RAM)  ? STEP_RAM  :
                        (state_q == S_SUM)  ? STEP_SUM  :
                        (state_q == S_DISP) ? STEP_DISP :
                        (state_q == S_CREG) ? STEP_CREG :
                        (state_q == S_DCMP) ? STEP_DCMP : STEP_NONE;
  assign periph_off_o = (state_q == S_HOT);
  assign tmr_start_o  = (state_q == S_TMR) & first;
  assign dma_start_o  = (state_q == S_DMA) & first;
  assign cop_init_o   = (state_q == S_COP) & first;
  assign cop_ack_o    = cop_take;
  assign sys_reset_o  = (state_q == S_RST);
  assign run_o        = st_run;
  assign lockout_o    = flags_q[FLG_LOCK];
  assign err_o        = '{flags: flags_q, code: code_q};

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_comb begin
    state_d   = state_q;
    lock_go   = 1'b0;
    lock_code = ERR_NONE;
    excess    = 1'b0;
    rst_go    = 1'b0;
    rst_code  = ERR_NONE;
    rst_bg    = 1'b0;
    cop_take  = 1'b0;
    retry     = 1'b0;
    unique case (state_q)
      S_CPU: begin
        if (step_ok) state_d = S_RAM;
        if (step_bad) begin lock_go = 1'b1; lock_code = ERR_CPU; end
      end
      S_RAM: begin
        if (step_ok) state_d = S_SUM;
        if (step_bad) begin lock_go = 1'b1; lock_code = ERR_RAM; end
      end
      S_SUM: begin
        if (step_ok) state_d = S_DISP;
        if (step_bad) begin lock_go = 1'b1; lock_code = ERR_SUM; end
      end
      S_DISP: begin
        if (step_ok) state_d = S_CREG;
        if (step_bad) begin lock_go = 1'b1; lock_code = ERR_DISP; end
      end
      S_CREG: begin
        if (step_ok) state_d = S_HOT;
        if (step_bad) begin lock_go = 1'b1; lock_code = creg_code; end
      end
      S_HOT: begin
        if (periph_irq_i) begin
          lock_go   = 1'b1;
          lock_code = ERR_HOT_IRQ;
        end else if (cnt_q == HOT_LAST) state_d = S_TMR;
      end
      S_TMR: begin
        if (tmr_done) begin
          if (tmr_dead) begin lock_go = 1'b1; lock_code = ERR_TMR_DEAD; end
          else if (tmr_fast_o | tmr_slow_o) begin
            lock_go   = 1'b1;
            lock_code = ERR_TMR_TOL;
          end else state_d = S_DMA;
        end
      end
      S_DMA: begin
        if (dma_irq_i) state_d = S_DCMP;
        else if (cnt_q == DMA_LAST) begin
          lock_go   = 1'b1;
          lock_code = ERR_DMA_TMO;
        end
      end
      S_DCMP: begin
        if (step_ok) state_d = S_COP;
        if (step_bad) begin lock_go = 1'b1; lock_code = ERR_DMA_CMP; end
      end
      S_COP: begin
        if (cop_ready_i) state_d = S_RUN;
        else if (cnt_q == INIT_LAST) begin
          if (tries_q == COP_INIT_TRIES - 2'd1) begin
            lock_go   = 1'b1;
            lock_code = ERR_COP_INIT;
          end else retry = 1'b1;
        end
      end
      S_RUN: begin
        if (bg_ram_fail_i) begin
          rst_go = 1'b1; rst_code = ERR_RAM; rst_bg = 1'b1;
        end else if (sum_two) begin
          rst_go = 1'b1; rst_code = ERR_SUM; rst_bg = 1'b1;
        end else if (cop_now | oos_due) begin
          cop_take = 1'b1;
          if (cop_rst_q == COP_RESET_LIMIT) begin
            lock_go = 1'b1; lock_code = cop_rep_i.code;
          end else begin
            rst_go = 1'b1; rst_code = cop_rep_i.code;
          end
        end else if (app_err_i) begin
          rst_go = 1'b1; rst_code = app_code_i;
        end
      end
      S_RST:  state_d = S_CPU;
      S_LOCK: state_d = S_LOCK;
      default: begin lock_go = 1'b1; lock_code = code_q; end
    endcase
    // hardware restart overrides any pending software reset cause, but not a lockout
    if (hw_reset_i && state_q != S_LOCK && !lock_go) begin
      rst_go = 1'b1; rst_code = ERR_NONE; rst_bg = 1'b0;
    end
    if (rst_go) begin
      if (rst_cnt_q >= RESET_LIMIT - 7'd1) begin
        lock_go   = 1'b1;
        excess    = 1'b1;
        lock_code = (rst_code != ERR_NONE) ? rst_code : ERR_EXCESS;
      end else state_d = S_RST;
    end
    if (lock_go) state_d = S_LOCK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and counters
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= S_CPU;
      cnt_q   <= '0;
      tries_q <= '0;
    end else begin
      state_q <= state_d;
      // saturating so entry strobes fire only once per state entry or S_COP retry
      if (state_d != state_q || retry) cnt_q <= '0;
      else if (cnt_q != '1) cnt_q <= cnt_q + 1'b1;
      if (state_d == S_COP && state_q != S_COP) tries_q <= '0;
      else if (retry) tries_q <= tries_q + 2'd1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_cnt_q  <= '0;
      cop_rst_q  <= '0;
      sum_fail_q <= '0;
    end else begin
      if (rst_go && rst_cnt_q != RESET_LIMIT) rst_cnt_q <= rst_cnt_q + 7'd1;
      if (rst_go && cop_take) cop_rst_q <= cop_rst_q + 2'd1;
      if (st_run && bg_sum_done_i) begin
        sum_fail_q <= bg_sum_fail_i && !sum_two ? sum_fail_q + 2'd1 : 2'd0;
      end
    end
  end

  // persistence timer for the handshake fault
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oos_q       <= '0;
      oos_alarm_o <= 1'b0;
    end else begin
      oos_alarm_o <= cop_oos & (state_q != S_LOCK);
      if (!cop_oos || !st_run || oos_due) oos_q <= '0;
      else oos_q <= oos_q + 1'b1;
    end
  end

  // only power-on clears these, except FLG_DIAG which clears when the coprocessor is ready; warm restarts keep the cause readable
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      code_q  <= ERR_NONE;
      flags_q <= '0;
    end else if (lock_go) begin
      code_q            <= lock_code;
      flags_q[FLG_LOCK] <= 1'b1;
      if (excess) flags_q[FLG_EXC] <= 1'b1;
    end else if (rst_go) begin
      code_q <= rst_code;
      if (rst_bg) begin
        flags_q[FLG_BG]   <= 1'b1;
        flags_q[FLG_DIAG] <= 1'b1;
      end
    end else if (state_q == S_COP && cop_ready_i) begin
      flags_q[FLG_DIAG] <= 1'b0;
    end
  end

  tmr_tol_check #(
    .NOM_CYC (TMR_NOM_CYC_P),
    .MAX_CYC (TMR_MAX_CYC_P),
    .CW      (TCW)
  ) u_tmr (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .start_i   (tmr_start_o),
    .irq_i     (tmr_irq_i),
    .done_o    (tmr_done),
    .dead_o    (tmr_dead),
    .fast_o    (tmr_fast_o),
    .slow_o    (tmr_slow_o),
    .count_o   (tmr_count_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  chk_lock_held: assert property (lockout_o |=> lockout_o && state_q == S_LOCK)
    else $error("lockout released without power-on");
  chk_cpu_code: assert property (state_q == S_CPU && step_bad
    |=> lockout_o && code_q == ERR_CPU) else $error("cpu failure code wrong");
  chk_hw_code: assert property (hw_reset_i && !lockout_o && !lock_go
    |=> code_q == ERR_NONE && !lockout_o && sys_reset_o) else $error("hw reset handling wrong");
  chk_excess_flags: assert property (excess
    |=> flags_q[FLG_EXC] && flags_q[FLG_LOCK] && rst_cnt_q == RESET_LIMIT)
    else $error("excess reset lockout wrong");
  chk_sum_single: assert property (st_run && bg_sum_done_i && bg_sum_fail_i
    && sum_fail_q == 2'd0 && !bg_ram_fail_i && !cop_now && !oos_due && !app_err_i && !hw_reset_i
    |=> !sys_reset_o) else $error("single sum failure not tolerated");
  chk_tmr_dead: assert property (state_q == S_TMR && tmr_done && tmr_dead
    |=> code_q == ERR_TMR_DEAD && lockout_o) else $error("dead timer not locked");
  chk_hot_irq: assert property (periph_off_o && periph_irq_i
    |=> lockout_o && code_q == ERR_HOT_IRQ) else $error("hot interrupt missed");
  chk_dma_tmo: assert property (state_q == S_DMA && cnt_q == DMA_LAST && !dma_irq_i
    |=> code_q == ERR_DMA_TMO) else $error("dma timeout code wrong");
  // the code moves one edge after the cause, so look at last cycle's cause
  chk_rst_sat: assert property (rst_cnt_q <= RESET_LIMIT
    && ($stable(code_q) || $past(rst_go) || $past(lock_go)))
    else $error("reset count over limit or code changed idle");
  chk_reset_pulse: assert property ($rose(sys_reset_o)
    |=> !sys_reset_o ##0 step_req_o == STEP_CPU) else $error("restart does not rerun tests");

  cov_reach_run:  cover property (state_q == S_COP ##1 st_run);
  cov_bg_restart: cover property (st_run && bg_ram_fail_i ##1 sys_reset_o);
  cov_cop_lock:   cover property (cop_take && lock_go);
  cov_excess:     cover property (excess);
endmodule : lockout_supervisor
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lockout_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        pirq = 1'b0, raise = 1'b0, cok = 1'b1, hw = 1'b0, bram = 1'b0;
  logic        sdone = 1'b0, sfail = 1'b0, aerr = 1'b0;
  logic [7:0]  acode = 8'h00, ccode = 8'h00;
  logic [2:0]  bad = 3'h0;
  logic [3:0]  det = 4'h0;
  logic [15:0] tdly = 16'h0064, ddly = 16'h0005;
  logic [31:0] lf = 32'h00011F12;
  logic [7:0]  tcnt;
  logic        poff, tst, tirq, dst, dirq, cinit, crdy, cack, oos, srst, run, lock, fast, slow;
  step_e       step_req;
  step_rsp_s   step_rsp;
  cop_rep_s    cop_rep;
  err_rep_s    err;
  int          err_count = 0, samples_checked = 0, n_rst = 0, n_init = 0, cyc = 0;

  lockout_supervisor #(.TMR_NOM_CYC_P(100), .TMR_MAX_CYC_P(200), .DMA_TMO_CYC_P(50),
    .INIT_TMO_CYC_P(50), .OOS_CYC_P(100)) i_lockout_supervisor (
    .clk_sys_i(clk_sys), .arst_n_i(arst_n), .step_req_o(step_req), .step_rsp_i(step_rsp),
    .periph_off_o(poff), .periph_irq_i(pirq), .tmr_start_o(tst), .tmr_irq_i(tirq),
    .dma_start_o(dst), .dma_irq_i(dirq), .cop_init_o(cinit), .cop_ready_i(crdy),
    .cop_rep_i(cop_rep), .cop_ack_o(cack), .oos_alarm_o(oos), .hw_reset_i(hw),
    .bg_ram_fail_i(bram), .bg_sum_done_i(sdone), .bg_sum_fail_i(sfail), .app_err_i(aerr),
    .app_code_i(acode), .sys_reset_o(srst), .run_o(run), .lockout_o(lock), .err_o(err),
    .tmr_fast_o(fast), .tmr_slow_o(slow), .tmr_count_o(tcnt));
  far_side_model i_far_side_model (
    .clk_sys_i(clk_sys), .arst_n_i(arst_n), .step_req_i(step_req), .bad_step_i(bad),
    .detail_i(det), .step_rsp_o(step_rsp), .tmr_start_i(tst), .tmr_dly_i(tdly),
    .tmr_irq_o(tirq), .dma_start_i(dst), .dma_dly_i(ddly), .dma_irq_o(dirq),
    .cop_init_i(cinit), .cop_ok_i(cok), .cop_ready_o(crdy), .raise_i(raise),
    .code_i(ccode), .cop_ack_i(cack), .cop_rep_o(cop_rep));
  ////////////////////////////////////////////////////////////////////////////
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (srst === 1'b1) n_rst++;
    if (cinit === 1'b1) n_init++;
    if (cyc == 100000) begin
      err_count++;
      end_of_test();
    end
  end
  function automatic logic [7:0] exp_code(input logic [2:0] s, input logic [3:0] d);
    case (s)
      3'h1: return ERR_CPU;
      3'h2: return ERR_RAM;
      3'h3: return ERR_SUM;
      3'h4: return ERR_DISP;
      3'h5: return ERR_CREG_BASE + {4'h0, d};
      default: return ERR_DMA_CMP;
    endcase
  endfunction : exp_code
  task automatic rnd(input int n, output int v);
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    v = lf % n;
  endtask : rnd
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic settle();
    for (int k = 0; k < 9000 && run !== 1'b1 && lock !== 1'b1; k++) tick(1);
  endtask : settle
  // bits: raise, app error, hw reset, bg ram, bg sum fail, bg sum done
  task automatic pulse(input logic [5:0] m);
    {raise, aerr, hw, bram, sfail, sdone} = m;
    tick(1);
    {raise, aerr, hw, bram, sfail, sdone} = 6'h00;
  endtask : pulse
  task automatic boot(input logic [2:0] b, input logic [15:0] t, input logic [15:0] d,
                      input logic ok, input logic hot);
    arst_n = 1'b0;
    {bad, tdly, ddly, cok} = {b, t, d, ok};
    tick(20);
    n_rst = 0;
    n_init = 0;
    arst_n = 1'b1;
    if (hot) begin
      for (int k = 0; k < 200 && poff !== 1'b1; k++) tick(1);
      pulse(6'h00);
      pirq = 1'b1;
      tick(1);
      pirq = 1'b0;
    end
    settle();
  endtask : boot
  // the cause must survive the warm reset and the rerun of the tests
  task automatic expect_rst(input logic [8:0] e);
    int b;
    b = n_rst;
    for (int k = 0; k < 300 && n_rst == b && lock !== 1'b1; k++) tick(1);
    chk({7'h00, lock, err.code}, {7'h00, e});
    tick(3);
    settle();
    chk({7'h00, lock, err.code}, {7'h00, e});
  endtask : expect_rst
  task automatic end_of_test();
    $display("err_count %0d samples_checked %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int v;
    int w;
    rnd(7, v);
    rnd(40, w);
    boot(3'h0, 16'(97 + v), 16'(1 + w), 1'b1, 1'b0);
    chk({14'h0000, run, lock}, 16'h0002);
    chk(16'(tcnt), tdly);
    for (int i = 1; i <= 6; i++) begin
      rnd(10, v);
      det = 4'(v);
      boot(3'(i), 16'h0064, 16'h0005, 1'b1, 1'b0);
      chk({7'h00, lock, err.code}, {8'h01, exp_code(3'(i), det)});
    end
    boot(3'h0, 16'h0064, 16'h0005, 1'b1, 1'b1);
    chk({7'h00, lock, err.code}, {8'h01, ERR_HOT_IRQ});
    for (int i = 0; i < 3; i++) begin
      boot(3'h0, (i == 0) ? 16'h0000 : (i == 1) ? 16'h0060 : 16'h0068, 16'h0005, 1'b1, 1'b0);
      chk({6'h00, fast & (i != 0), slow & (i != 0), err.code},
          {6'h00, i == 1, i == 2, (i == 0) ? ERR_TMR_DEAD : ERR_TMR_TOL});
      chk(16'(tcnt), (i == 0) ? 16'h00C8 : tdly);
    end
    boot(3'h0, 16'h0064, 16'h0000, 1'b1, 1'b0);
    chk({7'h00, lock, err.code}, {8'h01, ERR_DMA_TMO});
    boot(3'h0, 16'h0064, 16'h0005, 1'b0, 1'b0);
    chk({4'h0, 3'(n_init), lock, err.code}, {4'h0, 3'h3, 1'b1, ERR_COP_INIT});
    boot(3'h0, 16'h0064, 16'h0005, 1'b1, 1'b0);
    pulse(6'h03);
    tick(20);
    chk(16'(n_rst), 16'h0000);
    pulse(6'h03);
    expect_rst({1'b0, ERR_SUM});
    pulse(6'h04);
    expect_rst({1'b0, ERR_RAM});
    chk({15'h0000, err.flags[FLG_BG]}, 16'h0001);
    rnd(100, v);
    acode = 8'h40 + 8'(v);
    pulse(6'h10);
    expect_rst({1'b0, acode});
    pulse(6'h08);
    expect_rst(9'h000);
    rnd(3, v);
    ccode = 8'h32 + 8'(v);
    for (int i = 0; i < 4; i++) begin
      pulse(6'h20);
      expect_rst({i == 3, ccode});
    end
    boot(3'h0, 16'h0064, 16'h0005, 1'b1, 1'b0);
    ccode = ERR_COP_OOS;
    pulse(6'h20);
    tick(50);
    chk({14'h0000, oos, cack}, 16'h0002);
    expect_rst({1'b0, ERR_COP_OOS});
    boot(3'h0, 16'h0064, 16'h0005, 1'b1, 1'b0);
    for (int i = 0; i < 99; i++) begin
      pulse(6'h08);
      tick(8);
    end
    chk({7'h00, lock, 8'(n_rst)}, 16'h0063);
    pulse(6'h08);
    tick(5);
    chk({err.flags, err.code}, 16'h8808);
    pulse(6'h08);
    tick(20);
    chk({7'h00, lock, 8'(n_rst)}, 16'h0163);
    boot(3'h0, 16'h0064, 16'h0005, 1'b1, 1'b0);
    chk({err.flags, err.code}, 16'h0000);
    end_of_test();
  end
endmodule : tb
`default_nettype wire

// ---- tmr_tol_check.sv ----
package lockout_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned HZ_PER_MHZ    = 1_000_000;
  // times in their own units
  localparam int unsigned TMR_NOM_US    = 1000;
  localparam int unsigned TMR_MAX_US    = 2000;
  localparam int unsigned TOL_PCT       = 3;
  localparam int unsigned PCT           = 100;
  localparam int unsigned DMA_TMO_US    = 200;
  localparam int unsigned HOT_WIN_US    = 50;
  localparam int unsigned INIT_TMO_US   = 1000;
  localparam int unsigned OOS_PERSIST_S = 5;
  // derived cycle counts
  localparam int unsigned TMR_NOM_CYC   = CLK_HZ / HZ_PER_MHZ * TMR_NOM_US;
  localparam int unsigned TMR_MAX_CYC   = CLK_HZ / HZ_PER_MHZ * TMR_MAX_US;
  localparam int unsigned DMA_TMO_CYC   = CLK_HZ / HZ_PER_MHZ * DMA_TMO_US;
  localparam int unsigned HOT_WIN_CYC   = CLK_HZ / HZ_PER_MHZ * HOT_WIN_US;
  localparam int unsigned INIT_TMO_CYC  = CLK_HZ / HZ_PER_MHZ * INIT_TMO_US;
  localparam int unsigned OOS_CYC       = CLK_HZ * OOS_PERSIST_S;
  // error codes
  localparam logic [7:0] ERR_NONE      = 8'h00;
  localparam logic [7:0] ERR_CPU       = 8'h01;
  localparam logic [7:0] ERR_RAM       = 8'h02;
  localparam logic [7:0] ERR_SUM       = 8'h03;
  localparam logic [7:0] ERR_EXCESS    = 8'h08;
  localparam logic [7:0] ERR_DISP      = 8'h09;
  localparam logic [7:0] ERR_CREG_BASE = 8'h11;
  localparam logic [7:0] ERR_HOT_IRQ   = 8'h1B;
  localparam logic [7:0] ERR_TMR_DEAD  = 8'h1C;
  localparam logic [7:0] ERR_TMR_TOL   = 8'h1D;
  localparam logic [7:0] ERR_DMA_TMO   = 8'h1E;
  localparam logic [7:0] ERR_DMA_CMP   = 8'h1F;
  localparam logic [7:0] ERR_SYS_MAX   = 8'h2F;
  localparam logic [7:0] ERR_COP_INIT  = 8'h31;
  localparam logic [7:0] ERR_COP_LAST  = 8'h35;
  localparam logic [7:0] ERR_COP_OOS   = 8'h35;
  // flag bit positions
  localparam int unsigned FLG_DIAG = 0;
  localparam int unsigned FLG_BG   = 2;
  localparam int unsigned FLG_EXC  = 3;
  localparam int unsigned FLG_LOCK = 7;
  // limits
  localparam logic [6:0] RESET_LIMIT     = 7'd100;
  localparam logic [1:0] SUM_FAIL_LIMIT  = 2'd2;
  localparam logic [1:0] COP_RESET_LIMIT = 2'd3;
  localparam logic [1:0] COP_INIT_TRIES  = 2'd3;
  localparam int unsigned CREG_COUNT     = 10;

  typedef enum logic [2:0] {
    STEP_NONE = 3'h0,
    STEP_CPU  = 3'h1,
    STEP_RAM  = 3'h2,
    STEP_SUM  = 3'h3,
    STEP_DISP = 3'h4,
    STEP_CREG = 3'h5,
    STEP_DCMP = 3'h6
  } step_e;

  typedef struct packed {
    logic       done;
    logic       pass;
    logic [3:0] detail;
  } step_rsp_s;

  typedef struct packed {
    logic       req;
    logic [7:0] code;
  } cop_rep_s;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] code;
  } err_rep_s;
endpackage : lockout_pkg

`timescale 1ns/1ps
`default_nettype none
module tmr_tol_check #(
  parameter int unsigned NOM_CYC = lockout_pkg::TMR_NOM_CYC,
  parameter int unsigned MAX_CYC = lockout_pkg::TMR_MAX_CYC,
  parameter int unsigned CW      = 17
) (
  input  wire logic          clk_sys_i,
  input  wire logic          arst_n_i,
  input  wire logic          start_i,
  input  wire logic          irq_i,
  output logic               done_o,
  output logic               dead_o,
  output logic               fast_o,
  output logic               slow_o,
  output logic [CW-1:0]      count_o
);
  import lockout_pkg::*;
  localparam logic [CW-1:0] LO_C  = CW'(NOM_CYC - NOM_CYC * TOL_PCT / PCT);
  localparam logic [CW-1:0] HI_C  = CW'(NOM_CYC + NOM_CYC * TOL_PCT / PCT);
  localparam logic [CW-1:0] MAX_C = CW'(MAX_CYC);

  logic          run_q;
  logic [CW-1:0] cnt_q;
  wire           hit    = run_q & irq_i;
  wire           expire = run_q & ~irq_i & (cnt_q == MAX_C);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_q   <= 1'b0;
      cnt_q   <= '0;
      done_o  <= 1'b0;
      dead_o  <= 1'b0;
      fast_o  <= 1'b0;
      slow_o  <= 1'b0;
      count_o <= '0;
    end else begin
      done_o <= hit | expire;
      if (start_i) begin
        run_q  <= 1'b1;
        // count elapsed cycles, so the start cycle already counts as one
        cnt_q  <= {{(CW-1){1'b0}}, 1'b1};
        dead_o <= 1'b0;
        fast_o <= 1'b0;
        slow_o <= 1'b0;
      end else if (hit | expire) begin
        run_q   <= 1'b0;
        count_o <= cnt_q;
        dead_o  <= expire;
        fast_o  <= hit & (cnt_q < LO_C);
        slow_o  <= hit & (cnt_q > HI_C);
      end else if (run_q) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule : tmr_tol_check
`default_nettype wire
